// ### gpiou_pkg.sv
// Package for the GPIO unit: register offsets, field positions, resets.
// Assumes a 32-bit AXI4-Lite register bus and two 32-pin ports.
package gpiou_pkg;
    localparam int NPORT = 2;
    localparam int PW = 32;
    localparam int NPINT = 8;
    localparam int NGRP = 2;
    localparam int AW = 12;
    // Whole-port registers, port p at base + 4*p
    localparam logic [11:0] OFF_DIR = 12'h0_000;
    localparam logic [11:0] OFF_OUT = 12'h0_010;
    localparam logic [11:0] OFF_SET = 12'h0_020;
    localparam logic [11:0] OFF_CLR = 12'h0_030;
    localparam logic [11:0] OFF_IN = 12'h0_040;
    // Pin interrupt registers
    localparam logic [11:0] OFF_PSEL = 12'h0_080;
    localparam logic [11:0] OFF_PMODE = 12'h0_0A0;
    localparam logic [11:0] OFF_PENR = 12'h0_0A4;
    localparam logic [11:0] OFF_PENF = 12'h0_0A8;
    localparam logic [11:0] OFF_PEDGE = 12'h0_0AC;
    localparam logic [11:0] OFF_IST = 12'h0_0B0;
    localparam logic [11:0] OFF_IMSK = 12'h0_0B4;
    // Group g, port p: enable at base + 0x10*g + 4*p, polarity +8, ctrl 0x0E0
    localparam logic [11:0] OFF_GEN = 12'h0_0C0;
    localparam logic [11:0] OFF_GPOL = 12'h0_0C8;
    localparam logic [11:0] OFF_GCTL = 12'h0_0E0;
    // Per-pin byte registers: pin n of port p at base + 4*(32*p + n)
    localparam logic [11:0] OFF_PIN = 12'h0_400;
    localparam logic [11:0] PIN_SPAN = 12'h0_100;
    // Status bits: pin interrupts 7:0, groups 9:8
    localparam int IST_GRP = 8;
    localparam int IST_W = NPINT + NGRP;
    localparam int GCTL_AND = 0;
    localparam logic [31:0] RST_ZERO = 32'h0000_0000;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : gpiou_pkg

// ### gpiou_sync.sv
// Two-flop synchroniser with edge detect on the second stage output.
// Assumes asynchronous pins; first stage feeds only the second.
`timescale 1ns/1ns
module gpiou_sync #(
    parameter int W = 32
) (
    input wire logic clock_i,
    input wire logic sys_rst_i,
    input wire logic [W-1:0] pin_i,
    output logic [W-1:0] lvl_o,
    output logic [W-1:0] rise_o,
    output logic [W-1:0] fall_o
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;

    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
        end else begin
            s1_q <= pin_i;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    assign lvl_o = s2_q;
    assign rise_o = s2_q & ~s3_q;
    assign fall_o = ~s2_q & s3_q;
endmodule : gpiou_sync

// ### gpiou_top.sv
// GPIO unit top: two ports, eight pin interrupts, two group interrupts.
// Assumes an AXI4-Lite master on clock_i and pads outside doing tri-state.
//
// Local design decisions: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ns

// Operation
// [RQ1] Each pin has a direction bit software may change at any time.
// [RQ2] A set or clear write changes only the selected output bits.
// [RQ3] A whole port output value is written in one bus access.
// [RQ4] Per-pin registers read one pin level and drive one pin output.
// [RQ5] Interrupts may be on level, rising, falling, or both edges.
// [RQ6] Eight pin interrupts each pick any GPIO pin by a selector.
// [RQ7] Two group interrupts each combine pins from all ports.
// [RQ8] Any pin or set of pins of a port can be enrolled in a group.
// [RQ9] After reset all pins are inputs and all interrupts disabled.
// [RQ10] Registers sit on their own bus slave for short access latency.
// [RQ11] Pins are synchronised before edge detect; edges stay latched.
// [RQ12] A group fires on a polarity match, ANDed or ORed over pins.
module gpiou_top (
    input wire logic clock_i,
    input wire logic sys_rst_i,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [63:0] pin_i,
    output logic [63:0] pin_o,
    output logic [63:0] pin_oe_o,
    output logic irq_o
);
    localparam int N = gpiou_pkg::NPORT * gpiou_pkg::PW;

    logic [N-1:0] dir_q;
    logic [N-1:0] out_q;
    logic [N-1:0] dir_d;
    logic [N-1:0] out_d;
    logic [5:0] psel_q [gpiou_pkg::NPINT];
    logic [7:0] pmode_q;
    logic [7:0] penr_q;
    logic [7:0] penf_q;
    logic [7:0] pedge_q;
    logic [7:0] pedge_d;
    logic [N-1:0] gen_q [gpiou_pkg::NGRP];
    logic [N-1:0] gpol_q [gpiou_pkg::NGRP];
    logic [1:0] gctl_q;
    logic [9:0] ist_q;
    logic [9:0] ist_d;
    logic [9:0] imsk_q;
    logic irq_q;

    // Synchronised pins and edges
    logic [N-1:0] lvl;
    logic [N-1:0] rise;
    logic [N-1:0] fall;

    gpiou_sync #(.W(N)) u_sync ( // RQ11
        .clock_i(clock_i),
        .sys_rst_i(sys_rst_i),
        .pin_i(pin_i),
        .lvl_o(lvl),
        .rise_o(rise),
        .fall_o(fall)
    );

    // Write channel: address and data taken in either order
    logic aw_q;
    logic w_q;
    logic [11:0] awa_q;
    logic [31:0] wd_q;
    logic [3:0] ws_q;
    logic bv_q;
    logic ar_q;
    logic rv_q;
    logic [31:0] rd_q;
    logic [1:0] rr_q;
    logic [1:0] br_q;

    wire aw_hs = s_axi_awvalid & s_axi_awready;
    wire w_hs = s_axi_wvalid & s_axi_wready;
    wire wr_go = aw_q & w_q & ~bv_q;
    wire rd_go = s_axi_arvalid & s_axi_arready;

    // Write decode
    wire [11:0] wa = {awa_q[11:2], 2'b00};
    wire [31:0] wdat = wd_q;
    wire wfull = &ws_q;
    wire w_pin = wa >= gpiou_pkg::OFF_PIN &&
        wa < gpiou_pkg::OFF_PIN + gpiou_pkg::PIN_SPAN;
    wire [5:0] w_pidx = wa[7:2];
    wire w_port_ok = wa[3:2] < 2'(gpiou_pkg::NPORT);
    wire w_p = wa[2];
    wire w_dir = wa[11:4] == gpiou_pkg::OFF_DIR[11:4] && w_port_ok;
    wire w_out = wa[11:4] == gpiou_pkg::OFF_OUT[11:4] && w_port_ok;
    wire w_set = wa[11:4] == gpiou_pkg::OFF_SET[11:4] && w_port_ok;
    wire w_clr = wa[11:4] == gpiou_pkg::OFF_CLR[11:4] && w_port_ok;
    wire w_in = wa[11:4] == gpiou_pkg::OFF_IN[11:4] && w_port_ok;
    wire w_psel = wa[11:5] == gpiou_pkg::OFF_PSEL[11:5];
    wire w_pmode = wa == gpiou_pkg::OFF_PMODE;
    wire w_penr = wa == gpiou_pkg::OFF_PENR;
    wire w_penf = wa == gpiou_pkg::OFF_PENF;
    wire w_pedge = wa == gpiou_pkg::OFF_PEDGE;
    wire w_ist = wa == gpiou_pkg::OFF_IST;
    wire w_imsk = wa == gpiou_pkg::OFF_IMSK;
    wire w_gen = wa[11:5] == gpiou_pkg::OFF_GEN[11:5] && !wa[3];
    wire w_gpol = wa[11:5] == gpiou_pkg::OFF_GPOL[11:5] && wa[3];
    wire w_gctl = wa == gpiou_pkg::OFF_GCTL;
    wire w_g = wa[4];
    wire w_ok = w_dir | w_out | w_set | w_clr | w_in | w_psel | w_pmode |
        w_penr | w_penf | w_pedge | w_ist | w_imsk | w_gen | w_gpol |
        w_gctl | w_pin;
    // Byte strobes mask whole-port writes lane by lane
    wire [31:0] bmask = {{8{ws_q[3]}}, {8{ws_q[2]}}, {8{ws_q[1]}},
        {8{ws_q[0]}}};

    // Pin interrupt source selection and detection
    logic [7:0] psrc;
    logic [7:0] prise;
    logic [7:0] pfall;
    logic [7:0] plvl_act;
    genvar gi;
    generate
        for (gi = 0; gi < gpiou_pkg::NPINT; gi++) begin : g_pint
            assign psrc[gi] = lvl[psel_q[gi]]; // RQ6
            assign prise[gi] = rise[psel_q[gi]];
            assign pfall[gi] = fall[psel_q[gi]];
            // Level mode: penr enables, penf picks active-high
            assign plvl_act[gi] = penr_q[gi] & (psrc[gi] == penf_q[gi]);
        end
    endgenerate

    // Edge latches; set wins over a clear in the same cycle
    wire [7:0] edge_set = ~pmode_q & ((prise & penr_q) |
        (pfall & penf_q)); // RQ5
    wire [7:0] edge_clr = wr_go && w_pedge ? wdat[7:0] : 8'h00;
    assign pedge_d = (pedge_q & ~edge_clr) | edge_set; // RQ11

    wire [7:0] pint = (pmode_q & plvl_act) | (~pmode_q & pedge_q); // RQ5

    // Group match per pin, combined by AND or OR
    logic [1:0] gint;
    generate
        for (gi = 0; gi < gpiou_pkg::NGRP; gi++) begin : g_grp
            wire [N-1:0] m = gen_q[gi] & ~(lvl ^ gpol_q[gi]); // RQ8
            // AND with no pins enrolled stays off
            assign gint[gi] = gctl_q[gi] ? (|gen_q[gi] &&
                (m == gen_q[gi])) : |m; // RQ12
        end
    endgenerate

    // Status: events set sticky bits, a read of status clears them
    wire rd_ist = rd_go && {s_axi_araddr[11:2], 2'b00} ==
        gpiou_pkg::OFF_IST;
    assign ist_d = (rd_ist ? 10'h000 : ist_q) | {gint, pint};

    // Port write next values
    always_comb begin
        dir_d = dir_q;
        out_d = out_q;
        if (wr_go) begin
            if (w_dir)
                dir_d[w_p*32 +: 32] = (dir_q[w_p*32 +: 32] & ~bmask) |
                    (wdat & bmask); // RQ1
            if (w_out)
                out_d[w_p*32 +: 32] = (out_q[w_p*32 +: 32] & ~bmask) |
                    (wdat & bmask); // RQ3
            if (w_set)
                out_d[w_p*32 +: 32] = out_q[w_p*32 +: 32] |
                    (wdat & bmask); // RQ2
            if (w_clr)
                out_d[w_p*32 +: 32] = out_q[w_p*32 +: 32] &
                    ~(wdat & bmask); // RQ2
            if (w_pin && ws_q[0])
                out_d[w_pidx] = wdat[0]; // RQ4
        end
    end

    // Read decode
    wire [11:0] ra = {s_axi_araddr[11:2], 2'b00};
    wire r_p = ra[2];
    wire r_port_ok = ra[3:2] < 2'(gpiou_pkg::NPORT);
    logic [31:0] rmux;
    logic rerr;
    always_comb begin
        rmux = gpiou_pkg::RST_ZERO;
        rerr = 1'b0;
        if (ra >= gpiou_pkg::OFF_PIN &&
            ra < gpiou_pkg::OFF_PIN + gpiou_pkg::PIN_SPAN)
            rmux = {31'h0000_0000, lvl[ra[7:2]]}; // RQ4
        else if (ra[11:4] == gpiou_pkg::OFF_DIR[11:4] && r_port_ok)
            rmux = dir_q[r_p*32 +: 32];
        else if ((ra[11:4] == gpiou_pkg::OFF_OUT[11:4] ||
            ra[11:4] == gpiou_pkg::OFF_SET[11:4]) && r_port_ok)
            rmux = out_q[r_p*32 +: 32];
        else if (ra[11:4] == gpiou_pkg::OFF_IN[11:4] && r_port_ok)
            rmux = lvl[r_p*32 +: 32];
        else if (ra[11:5] == gpiou_pkg::OFF_PSEL[11:5])
            rmux = {26'h000_0000, psel_q[ra[4:2]]};
        else if (ra == gpiou_pkg::OFF_PMODE)
            rmux = {24'h00_0000, pmode_q};
        else if (ra == gpiou_pkg::OFF_PENR)
            rmux = {24'h00_0000, penr_q};
        else if (ra == gpiou_pkg::OFF_PENF)
            rmux = {24'h00_0000, penf_q};
        else if (ra == gpiou_pkg::OFF_PEDGE)
            rmux = {24'h00_0000, pedge_q};
        else if (ra == gpiou_pkg::OFF_IST)
            rmux = {22'h00_0000, ist_q};
        else if (ra == gpiou_pkg::OFF_IMSK)
            rmux = {22'h00_0000, imsk_q};
        else if (ra[11:5] == gpiou_pkg::OFF_GEN[11:5] && !ra[3])
            rmux = gen_q[ra[4]][r_p*32 +: 32];
        else if (ra[11:5] == gpiou_pkg::OFF_GPOL[11:5] && ra[3])
            rmux = gpol_q[ra[4]][r_p*32 +: 32];
        else if (ra == gpiou_pkg::OFF_GCTL)
            rmux = {30'h0000_0000, gctl_q};
        else
            rerr = 1'b1;
    end

    // Bus handshake, one cycle from both halves to the response
    // Readies are flops fed from next-state terms, no gate on the outputs
    wire aw_n = (aw_q | aw_hs) & ~wr_go;
    wire w_n = (w_q | w_hs) & ~wr_go;
    wire bv_n = wr_go | (bv_q & ~s_axi_bready);
    wire rv_n = rd_go | (rv_q & ~s_axi_rready);
    logic awrdy_q;
    logic wrdy_q;
    logic ardy_q;
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            awrdy_q <= 1'b1;
            wrdy_q <= 1'b1;
            ardy_q <= 1'b1;
        end else begin
            awrdy_q <= ~aw_n & ~bv_n; // RQ10
            wrdy_q <= ~w_n & ~bv_n;
            ardy_q <= ~rv_n;
        end
    end
    assign s_axi_awready = awrdy_q;
    assign s_axi_wready = wrdy_q;
    assign s_axi_arready = ardy_q;
    assign s_axi_bvalid = bv_q;
    assign s_axi_bresp = br_q;
    assign s_axi_rvalid = rv_q;
    assign s_axi_rdata = rd_q;
    assign s_axi_rresp = rr_q;

    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            aw_q <= 1'b0;
            w_q <= 1'b0;
            awa_q <= '0;
            wd_q <= '0;
            ws_q <= '0;
            bv_q <= 1'b0;
            br_q <= gpiou_pkg::RESP_OKAY;
        end else begin
            if (aw_hs) begin
                aw_q <= 1'b1;
                awa_q <= s_axi_awaddr;
            end
            if (w_hs) begin
                w_q <= 1'b1;
                wd_q <= s_axi_wdata;
                ws_q <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_q <= 1'b0;
                w_q <= 1'b0;
                bv_q <= 1'b1;
                br_q <= w_ok ? gpiou_pkg::RESP_OKAY : gpiou_pkg::RESP_SLVERR;
            end else if (bv_q && s_axi_bready) begin
                bv_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rv_q <= 1'b0;
            rd_q <= gpiou_pkg::RST_ZERO;
            rr_q <= gpiou_pkg::RESP_OKAY;
        end else if (rd_go) begin
            rv_q <= 1'b1;
            rd_q <= rmux;
            rr_q <= rerr ? gpiou_pkg::RESP_SLVERR : gpiou_pkg::RESP_OKAY;
        end else if (rv_q && s_axi_rready) begin
            rv_q <= 1'b0;
        end
    end

    // Configuration registers; reset leaves inputs and no interrupts
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            dir_q <= '0; // RQ9
            out_q <= '0;
            pmode_q <= '0;
            penr_q <= '0; // RQ9
            penf_q <= '0; // RQ9
            pedge_q <= '0;
            imsk_q <= '0;
            gctl_q <= '0;
            ist_q <= '0;
            irq_q <= 1'b0;
            for (int i = 0; i < gpiou_pkg::NPINT; i++)
                psel_q[i] <= '0;
            for (int g = 0; g < gpiou_pkg::NGRP; g++) begin
                gen_q[g] <= '0; // RQ9
                gpol_q[g] <= '0;
            end
        end else begin
            dir_q <= dir_d;
            out_q <= out_d;
            pedge_q <= pedge_d;
            ist_q <= ist_d;
            irq_q <= |(ist_d & imsk_q);
            if (wr_go && w_psel && ws_q[0])
                psel_q[wa[4:2]] <= wdat[5:0]; // RQ6
            if (wr_go && w_pmode && ws_q[0])
                pmode_q <= wdat[7:0];
            if (wr_go && w_penr && ws_q[0])
                penr_q <= wdat[7:0];
            if (wr_go && w_penf && ws_q[0])
                penf_q <= wdat[7:0];
            if (wr_go && w_imsk && wfull)
                imsk_q <= wdat[9:0];
            if (wr_go && w_gctl && ws_q[0])
                gctl_q <= wdat[1:0];
            if (wr_go && w_gen)
                gen_q[w_g][w_p*32 +: 32] <= (gen_q[w_g][w_p*32 +: 32] &
                    ~bmask) | (wdat & bmask); // RQ8
            if (wr_go && w_gpol)
                gpol_q[w_g][w_p*32 +: 32] <= (gpol_q[w_g][w_p*32 +: 32] &
                    ~bmask) | (wdat & bmask); // RQ12
        end
    end

    // Pin outputs registered so pads see no decode glitches
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            pin_o <= '0;
            pin_oe_o <= '0; // RQ9
        end else begin
            pin_o <= out_d;
            pin_oe_o <= dir_d; // RQ1
        end
    end

    assign irq_o = irq_q; // RQ7
endmodule : gpiou_top

// ### gpiou_pads.sv
// Pad model for the GPIO unit: what the outside world puts on the pins.
// Assumes the bench supplies the level of every undriven pin on ext_i.
`timescale 1ns/1ns
module gpiou_pads (
    input wire logic [63:0] ext_i,
    input wire logic [63:0] pin_o,
    input wire logic [63:0] pin_oe_o,
    output logic [63:0] pin_i
);
    // Driven pins read back their own value, the rest follow the bench
    assign pin_i = (pin_o & pin_oe_o) | (ext_i & ~pin_oe_o);
endmodule : gpiou_pads

// ### gpiou_checker.sv
// Checker for the GPIO unit top: bus handshakes and pin output timing.
// Assumes it is bound into gpiou_top and sees only its ports.
`timescale 1ns/1ns
module gpiou_checker (
    input wire logic clock_i,
    input wire logic sys_rst_i,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [63:0] pin_o,
    input wire logic [63:0] pin_oe_o,
    input wire logic irq_o
);
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (sys_rst_i);
    sequence s_wr_take;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_rd_take;
        s_axi_arvalid && s_axi_arready;
    endsequence
    property p_rst_idle;
        $fell(sys_rst_i) |-> pin_oe_o == '0 && !irq_o;
    endproperty
    a_rst_idle: assert property (p_rst_idle)
        else $error("pin driven or irq high after reset");
    // Pins may only move with the write that lands, never on their own
    property p_oe_move;
        $changed(pin_oe_o) |-> $rose(s_axi_bvalid);
    endproperty
    a_oe_move: assert property (p_oe_move)
        else $error("direction changed without a write");
    property p_out_move;
        $changed(pin_o) |-> $rose(s_axi_bvalid);
    endproperty
    a_out_move: assert property (p_out_move)
        else $error("output changed without a write");
    property p_b_lat;
        s_wr_take |-> ##[1:3] s_axi_bvalid;
    endproperty
    a_b_lat: assert property (p_b_lat)
        else $error("write response late");
    property p_r_lat;
        s_rd_take |-> ##[1:2] s_axi_rvalid;
    endproperty
    a_r_lat: assert property (p_r_lat)
        else $error("read data late");
    property p_b_hold;
        s_axi_bvalid |=> $past(s_axi_bready)
            || (s_axi_bvalid && $stable(s_axi_bresp));
    endproperty
    a_b_hold: assert property (p_b_hold)
        else $error("write response dropped before taken");
    property p_r_hold;
        s_axi_rvalid |=> $past(s_axi_rready)
            || (s_axi_rvalid && $stable(s_axi_rdata));
    endproperty
    a_r_hold: assert property (p_r_hold)
        else $error("read data dropped before taken");
    property p_aw_ref;
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
    endproperty
    a_aw_ref: assert property (p_aw_ref)
        else $error("write accepted while response pending");
    property p_ar_ref;
        s_axi_rvalid |-> !s_axi_arready;
    endproperty
    a_ar_ref: assert property (p_ar_ref)
        else $error("read accepted while data pending");
    property p_err_zero;
        s_axi_rvalid && s_axi_rresp == gpiou_pkg::RESP_SLVERR
            |-> s_axi_rdata == gpiou_pkg::RST_ZERO;
    endproperty
    a_err_zero: assert property (p_err_zero)
        else $error("refused read returned data");
endmodule : gpiou_checker

bind gpiou_top gpiou_checker gpiou_checker_inst (.*);

// ### tb_top.sv
// Testbench for the GPIO unit: registers, pins, pin and group interrupts.
// Assumes the pad model drives pin_i and the checker is bound in.
`timescale 1ns/1ns
module tb_top;
    logic clock_i, sys_rst_i, irq_o;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rdat;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic s_axi_rvalid, s_axi_rready;
    logic [63:0] pin_i, pin_o, pin_oe_o, ext;
    int n_errors, check_count;
    typedef struct {bit wr; logic [11:0] a; logic [31:0] d; logic [1:0] r;}
        gpiou_row_t;
    // Write rows carry data to write, read rows the data expected
    gpiou_row_t rows [13] = '{
        '{1'h1, 12'h000, 32'h0000_00FF, 2'h0},
        '{1'h0, 12'h000, 32'h0000_00FF, 2'h0},
        '{1'h1, 12'h010, 32'h1234_5678, 2'h0},
        '{1'h0, 12'h010, 32'h1234_5678, 2'h0},
        '{1'h1, 12'h020, 32'h0000_0003, 2'h0},
        '{1'h0, 12'h020, 32'h1234_567B, 2'h0},
        '{1'h1, 12'h030, 32'h1230_0000, 2'h0},
        '{1'h1, 12'h404, 32'h0000_0000, 2'h0},
        '{1'h0, 12'h010, 32'h0004_5679, 2'h0},
        '{1'h0, 12'h400, 32'h0000_0001, 2'h0},
        '{1'h0, 12'h040, 32'hA5A5_0079, 2'h0},
        '{1'h1, 12'h200, 32'h0000_0000, 2'h2},
        '{1'h0, 12'h200, 32'h0000_0000, 2'h2}};

    gpiou_top gpiou_top_inst (.*);
    gpiou_pads gpiou_pads_inst (.ext_i(ext), .pin_o, .pin_oe_o, .pin_i);

    initial begin
        clock_i = 1'h0;
        forever #50 clock_i = ~clock_i;
    end

    task automatic print_verdict;
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : print_verdict

    task automatic chk(input string nm, input logic [63:0] seen, exp);
        check_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge clock_i);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        forever begin
            @(posedge clock_i);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
            if (s_axi_bvalid) break;
        end
        resp = s_axi_bresp;
        s_axi_bready <= 1'h0;
    endtask : wr

    task automatic rd(input logic [11:0] a);
        @(posedge clock_i);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        forever begin
            @(posedge clock_i);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
            if (s_axi_rvalid) break;
        end
        rdat = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'h0;
    endtask : rd

    // Six cycles covers synchroniser, edge latch, status and irq stages
    task automatic setp(input int n, input logic v);
        @(posedge clock_i);
        ext[n] <= v;
        repeat (6) @(posedge clock_i);
    endtask : setp

    task automatic ist(input logic [9:0] e);
        rd(gpiou_pkg::OFF_IST);
        chk("status", rdat[9:0], e);
    endtask : ist

    task automatic reset_chk;
        chk("oe", pin_oe_o, 64'h0);
        chk("irq", irq_o, 1'h0);
        rd(gpiou_pkg::OFF_DIR + 12'h004);
        chk("dir", rdat, 32'h0);
        rd(gpiou_pkg::OFF_IMSK);
        chk("mask", rdat, 32'h0);
    endtask : reset_chk

    initial begin
        repeat (20000) @(posedge clock_i);
        n_errors++;
        print_verdict();
    end

    initial begin
        sys_rst_i = 1'h1;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_arvalid, s_axi_rready} = '0;
        s_axi_wstrb = 4'hF;
        ext = 64'h0000_0000_A5A5_0000;
        repeat (2) @(posedge clock_i);
        sys_rst_i <= 1'h0;
        reset_chk();
        foreach (rows[i]) begin
            if (rows[i].wr) wr(rows[i].a, rows[i].d);
            else begin
                rd(rows[i].a);
                chk("rdata", rdat, rows[i].d);
            end
            chk("resp", resp, rows[i].r);
        end
        chk("oe", pin_oe_o[31:0], 32'h0000_00FF);
        chk("out", pin_o[7:0], 8'h79);
        // Only byte lane 1 of the port lands
        s_axi_wstrb <= 4'h2;
        wr(gpiou_pkg::OFF_OUT, 32'hFFFF_FFFF);
        s_axi_wstrb <= 4'hF;
        rd(gpiou_pkg::OFF_OUT);
        chk("lane", rdat, 32'h0004_FF79);
        // Pin interrupt 0 watches pin 40: rising, falling, both edges
        wr(gpiou_pkg::OFF_PSEL, 32'h0000_0028);
        wr(gpiou_pkg::OFF_IMSK, 32'h0000_0001);
        for (int m = 0; m < 3; m++) begin
            wr(gpiou_pkg::OFF_PENR, {31'h0, m != 1});
            wr(gpiou_pkg::OFF_PENF, {31'h0, m != 0});
            wr(gpiou_pkg::OFF_PEDGE, 32'h0000_00FF);
            setp(40, 1'h1);
            chk("irq rise", irq_o, m != 1);
            ist({9'h0, m != 1});
            // Latched edge holds status up until software clears it
            rd(gpiou_pkg::OFF_PEDGE);
            chk("edge latch", rdat[0], m != 1);
            wr(gpiou_pkg::OFF_PEDGE, 32'h0000_00FF);
            rd(gpiou_pkg::OFF_IST);
            setp(40, 1'h0);
            chk("irq fall", irq_o, m != 0);
            ist({9'h0, m != 0});
        end
        // Level high keeps status set across reads
        wr(gpiou_pkg::OFF_PMODE, 32'h0000_0001);
        setp(40, 1'h1);
        ist(10'h001);
        ist(10'h001);
        setp(40, 1'h0);
        rd(gpiou_pkg::OFF_IST);
        ist(10'h000);
        wr(gpiou_pkg::OFF_IMSK, 32'h0000_0000);
        setp(40, 1'h1);
        chk("irq masked", irq_o, 1'h0);
        ist(10'h001);
        // Level active low: high pin is idle, low pin requests
        wr(gpiou_pkg::OFF_PENF, 32'h0000_0000);
        rd(gpiou_pkg::OFF_IST);
        ist(10'h000);
        setp(40, 1'h0);
        ist(10'h001);
        wr(gpiou_pkg::OFF_PENR, 32'h0000_0000);
        // Group 1 enrols pins 41 and 42, both matching high
        wr(gpiou_pkg::OFF_IMSK, 32'h0000_0200);
        rd(gpiou_pkg::OFF_IST);
        setp(41, 1'h1);
        wr(gpiou_pkg::OFF_GEN + 12'h014, 32'h0000_0600);
        wr(gpiou_pkg::OFF_GPOL + 12'h014, 32'h0000_0600);
        repeat (4) @(posedge clock_i);
        chk("irq group", irq_o, 1'h1);
        ist(10'h200);
        wr(gpiou_pkg::OFF_GCTL, 32'h0000_0002);
        rd(gpiou_pkg::OFF_IST);
        ist(10'h000);
        setp(42, 1'h1);
        ist(10'h200);
        // Second reset in mid-run
        @(posedge clock_i);
        sys_rst_i <= 1'h1;
        repeat (2) @(posedge clock_i);
        sys_rst_i <= 1'h0;
        @(posedge clock_i);
        reset_chk();
        print_verdict();
    end
endmodule : tb_top
